// ==== hw/snp_regs.vh ====
// Constants for the serial-to-network packetizer: register map, fields, modes and timing.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
//
// Summary of operation
// - With MAC sending on, six MAC bytes go out first on each new session.
// - MAC sending and secure session are independent bits; neither clears the other.
// - With delay disabled, every serial byte ends its packet at once.
// - A packet ends when the configured separator sequence is matched.
// - Separator length runs from zero to four bytes; zero disables matching.
// - After a match, zero to three trailing bytes close the packet.
// - A packet ends after an idle gap of two character times.
// - In four-wire mode the line driver is enabled at all times.
// - No connection is accepted or opened in update or configuration mode.
// - Only one session at a time; further requests are refused.
// - With access restriction on, only the allowed MAC and IP may connect.
`ifndef SNP_REGS_VH
`define SNP_REGS_VH

`define SNP_ADR_CTRL 4'h0
`define SNP_ADR_SEP 4'h1
`define SNP_ADR_CHAR 4'h2
`define SNP_ADR_MAC_LO 4'h3
`define SNP_ADR_MAC_HI 4'h4
`define SNP_ADR_AMAC_LO 4'h5
`define SNP_ADR_AMAC_HI 4'h6
`define SNP_ADR_AIP 4'h7
`define SNP_ADR_AMASK 4'h8
`define SNP_ADR_STAT 4'h9
`define SNP_ADR_CNT 4'ha
`define SNP_ADR_EVENT 4'hb
`define SNP_ADR_SEP4 4'hc

`define SNP_CTRL_SEND_MAC 0
`define SNP_CTRL_SECURE 1
`define SNP_CTRL_NODELAY 2
`define SNP_CTRL_RESTRICT 3
`define SNP_CTRL_FOUR_WIRE 4
`define SNP_CTRL_CLIENT 5
`define SNP_CTRL_DUAL 6
`define SNP_CTRL_OPEN 7
`define SNP_CTRL_ISP 8
`define SNP_CTRL_CFG 9

`define SNP_SEP_LEN_LSB 0
`define SNP_SEP_OP_LSB 4
`define SNP_SEP_BYTES_LSB 8

`define SNP_CTRL_RST 10'h000
`define SNP_SEP_RST 32'h0000_0000
`define SNP_CHAR_RST 16'h0457
`define SNP_SEP4_RST 8'h00
// Own MAC after reset; the value is arbitrary and locally administered.
`define SNP_MAC_RST 48'h0200_0000_0001
`define SNP_MAC_BYTES 3'h6
`define SNP_SEP_MAX 3'h4
`define SNP_IDLE_CHARS 2
`define SNP_OP_NONE 2'h0

`endif

// ==== hw/snp_sep_match.v ====
// Separator matcher for the packetizer: keeps the last four bytes and compares them.
// Assumes a one-cycle byte strobe and a stable configuration while a packet is open.
`timescale 1ns/1ns
`default_nettype none
`include "snp_regs.vh"
module snp_sep_match #(
  parameter MAXLEN = 4
)
(
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_clear,
  input wire i_stb,
  input wire [7:0] i_byte,
  input wire [2:0] i_len,
  input wire [31:0] i_sep,
  output wire o_hit
);
  reg [31:0] hist_r;
  reg [2:0] fill_r;
  wire [31:0] cur;
  wire [31:0] mask;
  wire enough;
  integer k;
  reg [31:0] mask_v;

  // The byte arriving now joins the history before the compare.
  assign cur = {hist_r[23:0], i_byte};

  always @*
  begin
    mask_v = 32'h0000_0000;
    for (k = 0; k < MAXLEN; k = k + 1)
      if (k < i_len)
        mask_v[8*k +: 8] = 8'hff;
  end

  assign mask = mask_v;
  assign enough = ({1'b0, fill_r} + 4'h1) >= {1'b0, i_len};
  // Separator bytes are packed oldest in the highest used lane.
  assign o_hit = i_stb && (i_len != 3'h0) && enough && ((cur & mask) == (i_sep & mask));

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      hist_r <= 32'h0000_0000;
      fill_r <= 3'h0;
    end
    else if (i_clear)
    begin
      fill_r <= 3'h0;
    end
    else if (i_stb)
    begin
      hist_r <= cur;
      if (fill_r != `SNP_SEP_MAX)
        fill_r <= fill_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ==== hw/snp_packetizer.v ====
// Serial-to-network packetizer: session gating, MAC preamble and packet cutting.
// Assumes a Wishbone master, a serial receiver giving byte strobes and a network
// sink that takes one byte per cycle whenever o_net_valid is high and i_net_ready is high.
`timescale 1ns/1ns
`default_nettype none
`include "snp_regs.vh"
module snp_packetizer #(
  parameter CLK_HZ = 100000000
)
(
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [5:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_ser_stb,
  input wire [7:0] i_ser_byte,
  input wire i_ser_tx_busy,
  input wire i_conn_req,
  input wire [47:0] i_conn_mac,
  input wire [31:0] i_conn_ip,
  input wire i_conn_close,
  output reg o_conn_accept,
  output reg o_conn_refuse,
  output reg o_conn_open_req,
  output reg o_session,
  output reg [7:0] o_net_byte,
  output reg o_net_valid,
  output reg o_net_last,
  input wire i_net_ready,
  output reg o_line_drv_en
);
  localparam ST_IDLE = 2'h0;
  localparam ST_MAC = 2'h1;
  localparam ST_DATA = 2'h2;

  reg [9:0] ctrl_r;
  reg [31:0] sep_r;
  reg [15:0] char_r;
  reg [47:0] mac_r;
  reg [47:0] amac_r;
  reg [31:0] aip_r;
  reg [31:0] amask_r;
  reg [7:0] event_r;
  reg [1:0] st_r;
  reg [2:0] mac_idx_r;
  reg [1:0] tail_r;
  reg [17:0] idle_r;
  reg open_r;
  reg [15:0] pkt_cnt_r;
  reg [15:0] refuse_cnt_r;
  reg have_byte_r;
  reg [7:0] hold_r;
  reg hold_v_r;
  reg [7:0] sep4_r;
  reg [31:0] rd_word;

  wire wb_req;
  wire busy_mode;
  wire allowed;
  wire sep_hit;
  wire idle_done;
  wire [2:0] sep_len;
  wire [1:0] sep_op;
  wire out_free;
  wire [17:0] idle_lim;
  wire cut;
  wire [31:0] wr_word;
  wire [31:0] idle_prod;

  function [7:0] mac_byte;
    input [47:0] m;
    input [2:0] i;
    begin
      mac_byte = m[8*(5-i) +: 8];
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (s[b])
          merge[8*b +: 8] = d[8*b +: 8];
    end
  endfunction

  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign busy_mode = ctrl_r[`SNP_CTRL_ISP] || ctrl_r[`SNP_CTRL_CFG];
  // Restriction passes only a host whose MAC and masked IP both match.
  assign allowed = !ctrl_r[`SNP_CTRL_RESTRICT] ||
    ((i_conn_mac == amac_r) && ((i_conn_ip & amask_r) == (aip_r & amask_r)));
  assign sep_len = (sep_r[`SNP_SEP_LEN_LSB +: 3] > `SNP_SEP_MAX) ? `SNP_SEP_MAX :
    sep_r[`SNP_SEP_LEN_LSB +: 3];
  assign sep_op = sep_r[`SNP_SEP_OP_LSB +: 2];
  assign idle_prod = char_r * `SNP_IDLE_CHARS;
  assign idle_lim = idle_prod[17:0];
  assign idle_done = have_byte_r && (idle_r >= idle_lim);
  assign out_free = !o_net_valid || i_net_ready;

  // One read mux serves both the read data and the byte-lane merge of writes.
  always @*
  begin
    case (i_wb_adr[5:2])
      `SNP_ADR_CTRL: rd_word = {22'h0, ctrl_r};
      `SNP_ADR_SEP: rd_word = sep_r;
      `SNP_ADR_CHAR: rd_word = {16'h0, char_r};
      `SNP_ADR_MAC_LO: rd_word = mac_r[31:0];
      `SNP_ADR_MAC_HI: rd_word = {16'h0, mac_r[47:32]};
      `SNP_ADR_AMAC_LO: rd_word = amac_r[31:0];
      `SNP_ADR_AMAC_HI: rd_word = {16'h0, amac_r[47:32]};
      `SNP_ADR_AIP: rd_word = aip_r;
      `SNP_ADR_AMASK: rd_word = amask_r;
      `SNP_ADR_STAT: rd_word = {25'h0, hold_v_r, have_byte_r, tail_r, o_session, st_r};
      `SNP_ADR_CNT: rd_word = {refuse_cnt_r, pkt_cnt_r};
      `SNP_ADR_EVENT: rd_word = {24'h0, event_r};
      `SNP_ADR_SEP4: rd_word = {24'h0, sep4_r};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign wr_word = merge(rd_word, i_wb_dat, i_wb_sel);

  snp_sep_match #(
    .MAXLEN(4)
  ) u_match (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_clear(st_r != ST_DATA),
    .i_stb(i_ser_stb && (st_r == ST_DATA) && (tail_r == 2'h0)),
    .i_byte(i_ser_byte),
    .i_len(sep_len),
    .i_sep({sep4_r, sep_r[`SNP_SEP_BYTES_LSB +: 24]}),
    .o_hit(sep_hit)
  );

  // A byte closes the packet when no-delay is set, on a separator with no tail,
  // or as the last of the requested trailing bytes.
  assign cut = ctrl_r[`SNP_CTRL_NODELAY] ||
    (sep_hit && (sep_op == `SNP_OP_NONE)) ||
    (tail_r == 2'h1);

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_r <= `SNP_CTRL_RST;
      sep_r <= `SNP_SEP_RST;
      char_r <= `SNP_CHAR_RST;
      mac_r <= `SNP_MAC_RST;
      sep4_r <= `SNP_SEP4_RST;
      amac_r <= 48'h0000_0000_0000;
      aip_r <= 32'h0000_0000;
      amask_r <= 32'h0000_0000;
      event_r <= 8'h00;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h0000_0000;
      if (wb_req && i_wb_we)
      begin
        case (i_wb_adr[5:2])
          `SNP_ADR_CTRL: ctrl_r <= wr_word[9:0];
          `SNP_ADR_SEP: sep_r <= wr_word;
          `SNP_ADR_CHAR: char_r <= wr_word[15:0];
          `SNP_ADR_MAC_LO: mac_r[31:0] <= wr_word;
          `SNP_ADR_MAC_HI: mac_r[47:32] <= wr_word[15:0];
          `SNP_ADR_AMAC_LO: amac_r[31:0] <= wr_word;
          `SNP_ADR_AMAC_HI: amac_r[47:32] <= wr_word[15:0];
          `SNP_ADR_AIP: aip_r <= wr_word;
          `SNP_ADR_AMASK: amask_r <= wr_word;
          `SNP_ADR_EVENT: event_r <= wr_word[7:0];
          `SNP_ADR_SEP4: sep4_r <= wr_word[7:0];
          default: ;
        endcase
      end
      else if (wb_req)
        o_wb_dat <= rd_word;
    end
  end

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r <= ST_IDLE;
      o_session <= 1'b0;
      o_conn_accept <= 1'b0;
      o_conn_refuse <= 1'b0;
      o_conn_open_req <= 1'b0;
      open_r <= 1'b0;
      mac_idx_r <= 3'h0;
      tail_r <= 2'h0;
      idle_r <= 18'h0;
      have_byte_r <= 1'b0;
      hold_r <= 8'h00;
      hold_v_r <= 1'b0;
      o_net_byte <= 8'h00;
      o_net_valid <= 1'b0;
      o_net_last <= 1'b0;
      pkt_cnt_r <= 16'h0;
      refuse_cnt_r <= 16'h0;
    end
    else
    begin
      o_conn_accept <= 1'b0;
      o_conn_refuse <= 1'b0;
      o_conn_open_req <= 1'b0;
      open_r <= ctrl_r[`SNP_CTRL_OPEN];
      if (o_net_valid && i_net_ready)
        o_net_valid <= 1'b0;
      if (i_conn_req)
      begin
        if (o_session || busy_mode || !allowed)
        begin
          o_conn_refuse <= 1'b1;
          refuse_cnt_r <= refuse_cnt_r + 16'h1;
        end
        else
        begin
          o_conn_accept <= 1'b1;
          o_session <= 1'b1;
          mac_idx_r <= 3'h0;
          st_r <= ctrl_r[`SNP_CTRL_SEND_MAC] ? ST_MAC : ST_DATA;
        end
      end
      else if (ctrl_r[`SNP_CTRL_OPEN] && !open_r && !o_session && !busy_mode)
        o_conn_open_req <= 1'b1;
      if (o_session && (i_conn_close || busy_mode))
      begin
        o_session <= 1'b0;
        st_r <= ST_IDLE;
        tail_r <= 2'h0;
        have_byte_r <= 1'b0;
        hold_v_r <= 1'b0;
      end
      else
      begin
        case (st_r)
          ST_MAC:
          begin
            if (i_ser_stb && !hold_v_r)
            begin
              hold_r <= i_ser_byte;
              hold_v_r <= 1'b1;
            end
            if (out_free)
            begin
              o_net_byte <= mac_byte(mac_r, mac_idx_r);
              o_net_valid <= 1'b1;
              o_net_last <= (mac_idx_r == `SNP_MAC_BYTES - 3'h1);
              mac_idx_r <= mac_idx_r + 3'h1;
              if (mac_idx_r == `SNP_MAC_BYTES - 3'h1)
                st_r <= ST_DATA;
            end
          end
          ST_DATA:
          begin
            if ((i_ser_stb || hold_v_r) && out_free)
            begin
              o_net_byte <= hold_v_r ? hold_r : i_ser_byte;
              o_net_valid <= 1'b1;
              o_net_last <= cut;
              hold_v_r <= 1'b0;
              idle_r <= 18'h0;
              have_byte_r <= !cut;
              if (cut)
                pkt_cnt_r <= pkt_cnt_r + 16'h1;
              if (sep_hit && (sep_op != `SNP_OP_NONE))
                tail_r <= sep_op;
              else if (tail_r != 2'h0)
                tail_r <= tail_r - 2'h1;
            end
            else if (idle_done && out_free)
            begin
              o_net_byte <= 8'h00;
              o_net_valid <= 1'b0;
              o_net_last <= 1'b0;
              have_byte_r <= 1'b0;
              tail_r <= 2'h0;
              pkt_cnt_r <= pkt_cnt_r + 16'h1;
            end
            else if (have_byte_r)
              idle_r <= idle_r + 18'h1;
          end
          default:
          begin
            tail_r <= 2'h0;
            have_byte_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Four-wire keeps the driver on; two-wire drives only while sending.
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_line_drv_en <= 1'b0;
    else
      o_line_drv_en <= ctrl_r[`SNP_CTRL_FOUR_WIRE] | i_ser_tx_busy;
  end
endmodule
`default_nettype wire

// ==== tb/snp_pkt_props.sv ====
// Port checker for the packetizer.
// Assumes CTRL is written with all byte lanes enabled.
`timescale 1ns/1ns
`default_nettype none
module snp_pkt_props (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_wb_we,
  input wire [5:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire o_wb_ack,
  input wire i_ser_tx_busy,
  input wire i_conn_req,
  input wire i_conn_close,
  input wire o_conn_accept,
  input wire o_conn_refuse,
  input wire o_conn_open_req,
  input wire o_session,
  input wire [7:0] o_net_byte,
  input wire o_net_valid,
  input wire o_net_last,
  input wire i_net_ready,
  input wire o_line_drv_en
);
  reg [9:0] ctl_r;
  wire mode_lock = ctl_r[8] | ctl_r[9];
  always @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
      ctl_r <= 10'h000;
    else if (o_wb_ack && i_wb_we && i_wb_adr[5:2] == 4'h0)
      ctl_r <= i_wb_dat[9:0];
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  accept_cause_a: assert property (o_conn_accept |-> $past(i_conn_req) && !o_conn_refuse)
    else $error("accept without request");
  single_session_a: assert property (i_conn_req && o_session && !i_conn_close |=> o_conn_refuse)
    else $error("second session not refused");
  mode_refuse_a: assert property (i_conn_req && mode_lock |=> o_conn_refuse)
    else $error("request taken in locked mode");
  mode_no_open_a: assert property (mode_lock && $past(mode_lock) |-> !o_conn_open_req)
    else $error("open request in locked mode");
  four_wire_a: assert property (ctl_r[4] && $past(ctl_r[4]) |-> o_line_drv_en)
    else $error("driver off in four wire mode");
  busy_drive_a: assert property ($past(i_ser_tx_busy) |-> o_line_drv_en)
    else $error("driver off while sending");
  two_wire_idle_a: assert property (!ctl_r[4] && !$past(ctl_r[4]) && !$past(i_ser_tx_busy)
    |-> !o_line_drv_en)
    else $error("driver on while idle");
  stream_hold_a: assert property (o_net_valid && !i_net_ready
    |=> o_net_valid && $stable(o_net_byte) && $stable(o_net_last))
    else $error("stream byte changed while stalled");
endmodule
bind snp_packetizer snp_pkt_props u_props (.i_mclk, .i_reset_n, .i_wb_we, .i_wb_adr,
  .i_wb_dat, .o_wb_ack, .i_ser_tx_busy, .i_conn_req, .i_conn_close, .o_conn_accept,
  .o_conn_refuse, .o_conn_open_req, .o_session, .o_net_byte, .o_net_valid, .o_net_last,
  .i_net_ready, .o_line_drv_en);
`default_nettype wire

// ==== tb/snp_host_model.sv ====
// Remote host model: asks for sessions, ends them and takes network bytes.
// Assumes an answer one cycle after each request.
`timescale 1ns/1ns
`default_nettype none
module snp_host_model (
  input wire i_mclk,
  input wire i_slow,
  input wire i_valid,
  input wire [7:0] i_byte,
  input wire i_last,
  input wire i_accept,
  input wire i_refuse,
  output logic o_ready,
  output logic o_req,
  output logic [47:0] o_mac,
  output logic [31:0] o_ip,
  output logic o_close
);
  logic [8:0] rx_q[$];
  logic [1:0] ans;
  initial
  begin
    o_ready = 1'b1;
    o_req = 1'b0;
    o_mac = 48'h0;
    o_ip = 32'h0;
    o_close = 1'b0;
  end
  // Stalls on every other cycle when slow.
  always @(posedge i_mclk)
  begin
    o_ready <= i_slow ? ~o_ready : 1'b1;
    if (i_valid && o_ready)
      rx_q.push_back({i_last, i_byte});
  end
  task automatic request(input [47:0] mac, input [31:0] ip);
    @(posedge i_mclk);
    o_req <= 1'b1;
    o_mac <= mac;
    o_ip <= ip;
    @(posedge i_mclk);
    o_req <= 1'b0;
    o_mac <= ~mac;
    o_ip <= ~ip;
    #1;
    ans = {i_refuse, i_accept};
  endtask
  task automatic close;
    @(posedge i_mclk);
    o_close <= 1'b1;
    @(posedge i_mclk);
    o_close <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_snp_packetizer.sv ====
// Testbench for the packetizer: registers, sessions and packet cutting.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_snp_packetizer;
  logic i_mclk = 0, i_reset_n = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
  logic i_ser_stb = 0, i_ser_tx_busy = 0, slow = 0;
  logic [5:0] i_wb_adr = 0;
  logic [31:0] i_wb_dat = 0, rd, cnt0;
  logic [3:0] i_wb_sel = 0;
  logic [7:0] i_ser_byte = 0;
  wire [31:0] o_wb_dat, i_conn_ip;
  wire [47:0] i_conn_mac;
  wire [7:0] o_net_byte;
  wire o_wb_ack, i_conn_req, i_conn_close, o_conn_accept, o_conn_refuse, o_conn_open_req;
  wire o_session, o_net_valid, o_net_last, i_net_ready, o_line_drv_en;
  int num_errors = 0, checks = 0, opens = 0;
  always @(posedge i_mclk)
    opens <= opens + int'(o_conn_open_req);
  snp_packetizer u_dut (.i_mclk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_ser_stb, .i_ser_byte, .i_ser_tx_busy,
    .i_conn_req, .i_conn_mac, .i_conn_ip, .i_conn_close, .o_conn_accept, .o_conn_refuse,
    .o_conn_open_req, .o_session, .o_net_byte, .o_net_valid, .o_net_last, .i_net_ready,
    .o_line_drv_en);
  snp_host_model u_host (.i_mclk, .i_slow(slow), .i_valid(o_net_valid),
    .i_byte(o_net_byte), .i_last(o_net_last), .i_accept(o_conn_accept),
    .i_refuse(o_conn_refuse), .o_ready(i_net_ready), .o_req(i_conn_req),
    .o_mac(i_conn_mac), .o_ip(i_conn_ip), .o_close(i_conn_close));
  initial
    forever #5 i_mclk = ~i_mclk;
  task automatic give_verdict;
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input [63:0] seen, input [63:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic expire(input int n);
    if (n >= 100)
    begin
      num_errors++;
      give_verdict;
    end
  endtask
  task automatic wb(input logic w, input [3:0] idx, input [31:0] d);
    int n = 0;
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= {idx, 2'b00};
    i_wb_dat <= d;
    i_wb_sel <= 4'hf;
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (o_wb_ack !== 1'b1 && n < 100);
    expire(n);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic ser(input [7:0] b);
    @(posedge i_mclk);
    i_ser_stb <= 1'b1;
    i_ser_byte <= b;
    @(posedge i_mclk);
    i_ser_stb <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic take(input [8:0] exp);
    int n = 0;
    while (u_host.rx_q.size() == 0 && n < 100)
    begin
      @(posedge i_mclk);
      n++;
    end
    expire(n);
    chk(u_host.rx_q.pop_front(), exp, "net byte");
  endtask
  task automatic drv(input logic busy, input logic exp);
    @(posedge i_mclk);
    i_ser_tx_busy <= busy;
    repeat (2) @(posedge i_mclk);
    #1;
    chk(o_line_drv_en, exp, "line driver");
  endtask
  initial
  begin
    #500000;
    num_errors++;
    give_verdict;
  end
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    slow <= 1'b1;
    wb(0, 4'h2, 0);
    chk(rd, 32'h0000_0457, "char reset");
    wb(1, 4'hd, 32'hffff_ffff);
    wb(0, 4'hd, 0);
    chk(rd, 0, "unmapped");
    wb(1, 4'h2, 32'h8);
    wb(1, 4'h3, 32'h3344_5566);
    wb(1, 4'h4, 32'h0000_1122);
    wb(1, 4'h0, 32'h3);
    wb(0, 4'h0, 0);
    chk(rd, 32'h3, "ctrl");
    u_host.request(48'h0a0b_0c0d_0e0f, 32'h0a00_0001);
    chk(u_host.ans, 1, "accept");
    chk(o_session, 1, "session");
    ser(8'h41);
    for (int i = 5; i >= 0; i--)
      take({i == 0, 8'(48'h1122_3344_5566 >> (8 * i))});
    take(9'h041);
    u_host.request(48'h1, 32'h1);
    chk(u_host.ans, 2, "second");
    for (int k = 0; k < 3; k++)
    begin
      wb(1, 4'h1, 32'h000d_0a02 | (k << 4));
      ser(8'h0d);
      ser(8'h0a);
      take(9'h00d);
      take({k == 0, 8'h0a});
      for (int j = 1; j <= k; j++)
      begin
        ser(8'h30 | j[7:0]);
        take({j == k, 8'h30 | j[7:0]});
      end
    end
    wb(1, 4'hc, 32'h31);
    wb(1, 4'h1, 32'h3233_3404);
    for (int j = 1; j <= 4; j++)
    begin
      ser(8'h30 | j[7:0]);
      take({j == 4, 8'h30 | j[7:0]});
    end
    wb(1, 4'h1, 32'h000d_0a00);
    ser(8'h0d);
    ser(8'h0a);
    repeat (4) @(posedge i_mclk);
    wb(0, 4'ha, 0);
    cnt0 = rd;
    repeat (20) @(posedge i_mclk);
    wb(0, 4'ha, 0);
    chk(rd[15:0], cnt0[15:0] + 16'h1, "idle end");
    take(9'h00d);
    take(9'h00a);
    wb(1, 4'h0, 32'h7);
    for (int j = 0; j < 2; j++)
    begin
      ser(8'h55 + j[7:0]);
      take({1'b1, 8'h55 + j[7:0]});
    end
    u_host.close;
    chk(o_session, 0, "session end");
    wb(1, 4'h5, 32'haabb_ccdd);
    wb(1, 4'h6, 32'h0);
    wb(1, 4'h7, 32'hc0a8_0104);
    wb(1, 4'h8, 32'hffff_ffff);
    wb(1, 4'h0, 32'h8);
    for (int k = 0; k < 3; k++)
    begin
      u_host.request({16'h0, 32'haabb_ccdd ^ (k == 0)}, 32'hc0a8_0104 ^ (k == 1));
      chk(u_host.ans, k == 2 ? 1 : 2, "filter");
    end
    u_host.close;
    for (int k = 8; k < 10; k++)
    begin
      wb(1, 4'h0, 32'h80 | (32'h1 << k));
      u_host.request(48'h1, 32'h1);
      chk(u_host.ans, 2, "locked");
    end
    chk(opens, 0, "open locked");
    wb(1, 4'h0, 32'h0);
    u_host.request(48'h1, 32'h1);
    chk(u_host.ans, 1, "unlocked");
    u_host.close;
    wb(1, 4'h0, 32'h80);
    repeat (2) @(posedge i_mclk);
    chk(opens, 1, "open request");
    wb(1, 4'hb, 32'h2);
    wb(1, 4'h0, 32'h70);
    drv(1'b0, 1'b1);
    wb(1, 4'h0, 32'h0);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b0);
    give_verdict;
  end
endmodule
`default_nettype wire
